// ### core/cdl_delay_line.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Default form is a tapped shift stage of L-1 cycles plus one flop.
// - A segment gives at most 33 cycles: 32 from the stage, one flop.
// - Longer latencies chain several segments whose delays add to L.
// - Tapped stage delay equals five-bit tap select value plus one.
// - Memory form uses dual-port storage with write and read counters.
// - Memory latency is counter difference plus memory read latency.
// - Counters may be LFSR or binary if both follow one sequence.
// - Resettable line forces output to zero until stale data flushed.
// - No programmable initial contents are offered.
// - Each input word appears unchanged exactly L cycles later.
// - With enable low every stage holds its contents.
// - Synchronous reset restores initial state and overrides enable.
// - Latency zero is a plain wire and needs no enable use.
module cdl_delay_line
  import cdl_pkg::*;
#(
  parameter int WIDTH = CDL_DEF_WIDTH,
  parameter int LATENCY = CDL_DEF_LATENCY,
  parameter int STYLE = CDL_STYLE_SHIFT,
  parameter int AW = CDL_DEF_AW
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rst,
  input wire logic en,
  input wire logic [AW-1:0] delay_sel,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ****************************************
  // Flush tracking shared by both forms
  // ****************************************
  localparam int FLUSH_LEN = (STYLE == CDL_STYLE_RAM) ? (1 << AW) + 1 : LATENCY;
  localparam int FW = $clog2(FLUSH_LEN + 2);
  logic [FW-1:0] fill_r;
  logic [FW-1:0] fill_nxt;
  logic flushed;
  logic flushed_nxt;
  logic [FW-1:0] need;

  // Count enabled cycles since reset; output gated until line is clean
  assign need = (STYLE == CDL_STYLE_RAM) ? FW'(delay_sel) + FW'(CDL_RAM_RD_LAT) : FW'(LATENCY);
  assign flushed = (fill_r >= need);
  assign fill_nxt = (en && !flushed) ? fill_r + FW'(1) : fill_r;

  // Clean after this edge; the output flop loads zero until then
  assign flushed_nxt = (fill_nxt >= need);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fill_r <= '0;
    else if (rst)
      fill_r <= '0;
    else
      fill_r <= fill_nxt;
  end

  generate
    if (LATENCY == 0 && STYLE == CDL_STYLE_SHIFT)
    begin : g_wire
      // ****************************************
      // Zero latency collapses to a wire
      // ****************************************
      // Enable and synchronous reset are left unread here
      assign dout = din;
    end
    else if (STYLE == CDL_STYLE_SHIFT)
    begin : g_shift
      // ****************************************
      // Cascaded tapped shift segments
      // ****************************************
      localparam int NSEG = (LATENCY + CDL_SEG_MAX - 1) / CDL_SEG_MAX;
      logic [WIDTH-1:0] seg_in [NSEG+1];
      assign seg_in[0] = din;
      for (genvar s = 0; s < NSEG; s++)
      begin : g_seg
        // Last segment takes the remainder, earlier ones a full 33
        localparam int SEG_LAT = (s < NSEG - 1) ? CDL_SEG_MAX :
                                 LATENCY - (NSEG - 1) * CDL_SEG_MAX;
        localparam int STAGE_LEN = SEG_LAT - 1;
        localparam logic [CDL_TAP_BITS-1:0] TAP_SEL = CDL_TAP_BITS'(STAGE_LEN - 1);
        logic [WIDTH-1:0] stage_r [CDL_TAP_MAX];
        logic [WIDTH-1:0] tap_out;
        logic [WIDTH-1:0] term_r;
        // Only the last segment's flop carries the zero gate
        localparam bit IS_LAST = (s == NSEG - 1);
        logic [WIDTH-1:0] term_d;
        // No reset on the stage itself; contents only initialised by flushing
        always_ff @(posedge clk)
        begin
          if (en)
          begin
            stage_r[0] <= seg_in[s];
            for (int i = 1; i < CDL_TAP_MAX; i++)
              stage_r[i] <= stage_r[i-1];
          end
        end
        // Tapped read: delay is tap select plus one
        if (STAGE_LEN > 0)
        begin : g_tap
          assign tap_out = stage_r[TAP_SEL];
        end
        else
        begin : g_notap
          assign tap_out = seg_in[s];
        end
        // Last flop loads zero until stale words have been flushed out
        assign term_d = (IS_LAST && !flushed_nxt) ? '0 : tap_out;
        // Terminating flop of the segment
        always_ff @(posedge clk or negedge reset_n)
        begin
          if (!reset_n)
            term_r <= '0;
          else if (rst)
            term_r <= '0;
          else if (en)
            term_r <= term_d;
        end
        assign seg_in[s+1] = term_r;
      end
      // Output is the last segment's flop, already held at zero until flushed
      assign dout = seg_in[NSEG];

      // ****************************************
      // Checks of the shift form
      // ****************************************
      // Run of back-to-back enabled edges, saturating at the latency
      logic [FW-1:0] run_r;
      logic [FW-1:0] run_nxt;
      assign run_nxt = (run_r == FW'(LATENCY)) ? run_r : run_r + FW'(1);

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          run_r <= '0;
        else if (rst || !en)
          run_r <= '0;
        else
          run_r <= run_nxt;
      end

      // Zero output, held contents, reset, exact delay and flush count
      stale_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        !flushed |-> dout == '0) else $error("Output not zero before flush");
      hold_en_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!en && !rst) |=> $stable(seg_in[NSEG])) else $error("Line moved while disabled");
      reset_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
        rst |=> (fill_r == '0 && dout == '0)) else $error("Reset did not clear");
      exact_lat_a: assert property (@(posedge clk) disable iff (!reset_n || rst)
        (run_r == FW'(LATENCY) && flushed) |-> dout == $past(din, LATENCY))
        else $error("Latency mismatch");
      fill_sat_a: assert property (@(posedge clk) disable iff (!reset_n)
        need >= fill_r) else $error("Flush count ran past the latency");
    end
    else
    begin : g_ram
      // ****************************************
      // Dual-port memory with address counters
      // ****************************************
      logic [WIDTH-1:0] mem [1 << AW];
      logic [AW-1:0] wr_ptr_r;
      logic [AW-1:0] rd_ptr;
      logic [WIDTH-1:0] rd_data_r;
      logic [WIDTH-1:0] rd_word;
      logic [WIDTH-1:0] rd_gated;
      // Read address trails write address by the programmed delay
      assign rd_ptr = wr_ptr_r - delay_sel;
      // Both counters step together in binary order
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          wr_ptr_r <= '0;
        else if (rst)
          wr_ptr_r <= '0;
        else if (en)
          wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      // Write port; the storage itself is never reset
      always_ff @(posedge clk)
      begin
        if (en)
          mem[wr_ptr_r] <= din;
      end

      // Read word, forced to zero while stale entries could still come out
      assign rd_word = mem[rd_ptr];
      assign rd_gated = flushed_nxt ? rd_word : '0;

      // Registered read port, the one cycle of memory read latency
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          rd_data_r <= '0;
        else if (rst)
          rd_data_r <= '0;
        else if (en)
          rd_data_r <= rd_gated;
      end
      assign dout = rd_data_r;

      // ****************************************
      // Checks of the memory form
      // ****************************************
      // Gating, counter stepping, holding and reset of the memory form
      ram_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        !flushed |-> dout == '0) else $error("Memory output not gated");
      ram_step_a: assert property (@(posedge clk) disable iff (!reset_n || rst)
        en |=> wr_ptr_r == $past(wr_ptr_r) + AW'(1)) else $error("Counter stalled");
      ram_hold_a: assert property (@(posedge clk) disable iff (!reset_n || rst)
        !en |=> $stable(wr_ptr_r) && $stable(rd_data_r)) else $error("Moved while held");
      ram_rst_a: assert property (@(posedge clk) disable iff (!reset_n)
        rst |=> (wr_ptr_r == '0 && dout == '0)) else $error("Memory reset did not clear");
    end
  endgenerate

endmodule

// ### core/cdl_pkg.sv
package cdl_pkg;
  // ****************************************
  // Segment geometry of the structural form
  // ****************************************
  localparam int CDL_TAP_BITS = 5;             // Tap select field width
  localparam int CDL_TAP_MAX = 32;             // Longest tapped shift stage
  localparam int CDL_SEG_MAX = CDL_TAP_MAX + 1; // Stage plus terminating flop
  // ****************************************
  // Implementation styles and defaults
  // ****************************************
  localparam int CDL_STYLE_SHIFT = 0;          // Cascaded shift segments
  localparam int CDL_STYLE_RAM = 1;            // Dual-port memory with counters
  localparam int CDL_RAM_RD_LAT = 1;           // Memory read latency in cycles
  localparam int CDL_RAM_THRESH = 128;         // Length where memory form pays off
  localparam int CDL_DEF_WIDTH = 8;
  localparam int CDL_DEF_LATENCY = 64;
  localparam int CDL_DEF_AW = 8;
endpackage

// ### verif/cdl_delay_line_tb_top.sv
`timescale 1ns/10ps
// ****************************************
// Testbench of the delay line, two segments
// ****************************************
module cdl_delay_line_tb_top;
  import cdl_pkg::*;
  localparam int LAT = 40;
  logic clk, reset_n, rst, en;
  logic [7:0] din, dout, w;
  logic [7:0] dout_mem, dout_wire;
  logic [7:0] hist[$];
  int num_errors, n_tests;
  cdl_src_model u_src (.clk(clk), .reset_n(reset_n), .en(en), .word_r(din));
  // Shift form, well below the length where the memory form pays off
  cdl_delay_line #(.LATENCY(LAT)) u_dut (.clk(clk), .reset_n(reset_n), .rst(rst),
    .en(en), .delay_sel(8'h00), .din(din), .dout(dout));
  // Memory form set to the same delay, so both must agree word for word
  cdl_delay_line #(.LATENCY(LAT), .STYLE(CDL_STYLE_RAM)) u_dut_mem (.clk(clk),
    .reset_n(reset_n), .rst(rst), .en(en), .delay_sel(8'(LAT - CDL_RAM_RD_LAT)),
    .din(din), .dout(dout_mem));
  // Zero latency with no enable in use
  cdl_delay_line #(.LATENCY(0)) u_dut_wire (.clk(clk), .reset_n(reset_n), .rst(1'b0),
    .en(1'b1), .delay_sel(8'h00), .din(din), .dout(dout_wire));
  // Clock of 25 ns
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Words taken by the line since the last reset
  always @(posedge clk)
  begin
    if (!reset_n || rst)
      hist.delete();
    else if (en)
      hist.push_back(din);
  end
  // Every cycle: zero until flushed, then the word taken LAT enabled edges ago
  always @(negedge clk)
  begin
    if (reset_n)
    begin
      w = (hist.size() >= LAT) ? hist[hist.size()-LAT] : 8'h00;
      chk(dout, w);
      chk(dout_mem, w);
      chk(dout_wire, din);
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n, input logic e, input logic r);
    repeat (n)
    begin
      @(negedge clk);
      en = e;
      rst = r;
    end
  endtask
  // Zero output over the first LAT-1 enabled edges, first word at edge LAT
  task automatic t_flush();
    cyc(40, 1'b1, 1'b0);
    chk(dout, 8'h00);
    chk(dout_mem, 8'h00);
    cyc(1, 1'b1, 1'b0);
    chk(dout, hist[0]);
    chk(dout_mem, hist[0]);
    $display("flush test done");
  endtask
  // Output stands while enable is low, then gapped stream
  task automatic t_hold();
    logic [7:0] held;
    cyc(1, 1'b0, 1'b0);
    held = hist[hist.size()-LAT];
    cyc(6, 1'b0, 1'b0);
    chk(dout, held);
    chk(dout_mem, held);
    repeat (30)
    begin
      cyc(1, 1'b1, 1'b0);
      cyc(1, 1'b0, 1'b0);
    end
    $display("hold test done");
  endtask
  // Synchronous reset with enable high, so reset must win, then back-to-back words
  task automatic t_rst();
    cyc(1, 1'b1, 1'b1);
    cyc(1, 1'b0, 1'b0);
    chk(dout, 8'h00);
    chk(dout_mem, 8'h00);
    cyc(45, 1'b1, 1'b0);
    chk(dout, hist[hist.size()-LAT]);
    chk(dout_mem, hist[hist.size()-LAT]);
    $display("sync reset test done");
  endtask
  // Async reset in mid-stream, then flush again
  task automatic t_areset();
    @(negedge clk);
    reset_n = 1'b0;
    en = 1'b0;
    cyc(3, 1'b0, 1'b0);
    reset_n = 1'b1;
    t_flush();
    $display("async reset test done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    rst = 1'b0;
    en = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_flush();
    t_hold();
    t_rst();
    t_areset();
    stop_test();
  end
endmodule

// ### verif/cdl_src_model.sv
`timescale 1ns/10ps
// ****************************************
// Upstream source of the delay line
// ****************************************
module cdl_src_model
  import cdl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en,
  output logic [CDL_DEF_WIDTH-1:0] word_r
);
  // Registered word stream, a new word every enabled cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      word_r <= 8'h5a; // Nonzero, so the first word differs from the flush zero
    else if (en)
      word_r <= word_r + 8'h3b;
  end
endmodule
